// ---- isb_fill_encoder.sv ----
// Registered 3-bit averaging buffer fill code
`timescale 1ns/100ps
module isb_fill_encoder
  import isb_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Fill link
  isb_fill_if.fill fill
);

  // Code n when n/8 < fraction <= (n+1)/8, clamped to 0..7
  function automatic isb_code_t fill_code(input isb_sec_t cnt, input isb_sec_t exp_n);
    logic [18:0] scaled;
    logic [18:0] q;
    scaled = {cnt, 3'b000};
    q = 19'h0;
    if (cnt != 16'h0000 && exp_n != 16'h0000) begin
      q = (scaled - 19'h1) / {3'b000, exp_n};
    end
    if (q > 19'h7) begin
      q = 19'h7;
    end
    return q[2:0];
  endfunction : fill_code

  // Fill code register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill.code <= 3'h0;
    end else if (ce_i) begin
      fill.code <= fill_code(fill.count, fill.expected); // [R3]
    end
  end

  AST_FILL_CODE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R3]
    (ce_i && fill.count != 16'h0000 && fill.count <= fill.expected) |=>
    (({16'h0000, fill.code} + 19'h1) * $past(fill.expected) >= 35'($past(fill.count)) * 8 &&
     {16'h0000, fill.code} * $past(fill.expected) < 35'($past(fill.count)) * 8))
    else $error("fill code outside its eighth band");
endmodule : isb_fill_encoder

// ---- isb_fill_if.sv ----
// Link between the encoder core and the fill code stage
`timescale 1ns/100ps
interface isb_fill_if;
  import isb_pkg::*;
  isb_sec_t count;
  isb_sec_t expected;
  isb_code_t code;
  modport core (output count, output expected, input code);
  modport fill (input count, input expected, output code);
endinterface : isb_fill_if

// ---- isb_host_model.sv ----
// Host logger model that latches the status byte of each telegram
`timescale 1ns/100ps
module isb_host_model
  import isb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Telegram trigger and status byte
  input wire logic tick_1s_i,
  input wire logic [7:0] status_i,
  output isb_byte_t telegram_o
);
  // One telegram a second, taken on the measuring tick
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      telegram_o <= 8'h00;
    end else if (tick_1s_i) begin
      telegram_o <= status_i;
    end
  end
endmodule : isb_host_model

// ---- isb_pkg.sv ----
// Types shared by the status byte encoder modules
package isb_pkg;
  typedef logic [15:0] isb_sec_t;
  typedef logic [2:0] isb_code_t;
  typedef logic [7:0] isb_byte_t;
endpackage : isb_pkg

// ---- isb_regs.svh ----
// Register offsets, reset values and timing counts of the status byte encoder
`ifndef ISB_REGS_SVH
`define ISB_REGS_SVH
`define ISB_OFS_CTRL 8'h00
`define ISB_OFS_STATUS 8'h04
`define ISB_OFS_IRQ_STAT 8'h08
`define ISB_OFS_IRQ_MASK 8'h0C
`define ISB_CTRL_AVG_RST 16'h000A
`define ISB_IRQ_MASK_RST 3'h0
`define ISB_BIT_GEN 0
`define ISB_BIT_FILL_LO 1
`define ISB_BIT_FILL_HI 3
`define ISB_BIT_RSVD 4
`define ISB_BIT_STATIC 5
`define ISB_BIT_HCRIT 6
`define ISB_BIT_HEAT 7
`define ISB_IRQ_GEN 0
`define ISB_IRQ_STATIC 1
`define ISB_IRQ_HEAT 2
`define ISB_GEN_SECONDS 8'h0A
`define ISB_STATIC_SECONDS 8'h3C
`endif

// ---- isb_status_encoder.sv ----
// Instrument status byte encoder with APB registers and interrupt
//
// Overview of operation
// [R1] Averaging under 10 s: general fault after 10 s without a new value.
// [R2] Averaging 10 s or more: general fault when buffer holds under half.
// [R3] Bits 1..3 give buffer fill as 3-bit code in eighths.
// [R4] Bit 5 flags a static fault lasting longer than one minute.
// [R5] Bit 6 follows the heating switch-on criterion.
// [R6] Bit 7 follows the heating on state.
// [R7] Bit 4 always reads zero.
`timescale 1ns/100ps
`include "isb_regs.svh"
module isb_status_encoder
  import isb_pkg::*;
#(
  parameter int AW = 8
)
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Measurement core and heating control
  input wire logic tick_1s_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] buf_count_i,
  input wire logic sound_temperature_limit_i,
  input wire logic heat_crit_i,
  input wire logic heat_on_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Results
  output logic [7:0] status_o,
  output logic irq_o
);

  if (AW < 4 || AW > 32) begin : g_chk
    $error("isb_status_encoder: AW must lie in 4..32");
  end

  isb_fill_if fif ();
  isb_sec_t avg_r;
  logic [7:0] nov_cnt_r;
  logic [7:0] lim_cnt_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic gen_nxt;
  logic static_nxt;
  logic [2:0] evt;
  logic setup;
  logic wr;
  logic [7:0] ofs;

  // Saturating one-second increment
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction : sat_inc

  assign fif.count = buf_count_i;
  assign fif.expected = avg_r;

  isb_fill_encoder u_fill (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .fill(fif.fill)
  );

  // Bus decode
  assign ofs = 8'(paddr_i[AW-1:0]);
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;

  // Seconds since the last new measured value
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nov_cnt_r <= 8'h00;
    end else if (ce_i) begin
      if (sample_valid_i) begin
        nov_cnt_r <= 8'h00;
      end else if (tick_1s_i) begin
        nov_cnt_r <= sat_inc(nov_cnt_r);
      end
    end
  end

  // Seconds of unbroken temperature-limit violation
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim_cnt_r <= 8'h00;
    end else if (ce_i) begin
      if (!sound_temperature_limit_i) begin
        lim_cnt_r <= 8'h00;
      end else if (tick_1s_i) begin
        lim_cnt_r <= sat_inc(lim_cnt_r);
      end
    end
  end

  // Fault conditions
  always_comb begin
    if (avg_r < 16'(`ISB_GEN_SECONDS)) begin
      gen_nxt = (nov_cnt_r >= `ISB_GEN_SECONDS); // [R1]
    end else begin
      gen_nxt = ({buf_count_i, 1'b0} < {1'b0, avg_r}); // [R2]
    end
    static_nxt = (lim_cnt_r > `ISB_STATIC_SECONDS) || (nov_cnt_r > `ISB_STATIC_SECONDS); // [R4]
  end

  // Status byte
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= 8'h00;
    end else if (ce_i) begin
      status_o[`ISB_BIT_GEN] <= gen_nxt; // [R1] [R2]
      status_o[`ISB_BIT_FILL_HI:`ISB_BIT_FILL_LO] <= fif.code; // [R3]
      status_o[`ISB_BIT_RSVD] <= 1'b0; // [R7]
      status_o[`ISB_BIT_STATIC] <= static_nxt; // [R4]
      status_o[`ISB_BIT_HCRIT] <= heat_crit_i; // [R5]
      status_o[`ISB_BIT_HEAT] <= heat_on_i; // [R6]
    end
  end

  // Rising edges of faults, any heating change
  assign evt[`ISB_IRQ_GEN] = gen_nxt && !status_o[`ISB_BIT_GEN];
  assign evt[`ISB_IRQ_STATIC] = static_nxt && !status_o[`ISB_BIT_STATIC];
  assign evt[`ISB_IRQ_HEAT] = heat_on_i != status_o[`ISB_BIT_HEAT];

  // Averaging time control register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_r <= `ISB_CTRL_AVG_RST;
    end else if (ce_i && wr && ofs == `ISB_OFS_CTRL) begin
      avg_r <= pwdata_i[15:0];
    end
  end

  // Sticky events, set beats write-one clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= 3'h0;
    end else if (ce_i) begin
      if (wr && ofs == `ISB_OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata_i[2:0]) | (ce_i ? evt : 3'h0);
      end else begin
        irq_stat_r <= irq_stat_r | evt;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= `ISB_IRQ_MASK_RST;
    end else if (ce_i && wr && ofs == `ISB_OFS_IRQ_MASK) begin
      irq_mask_r <= pwdata_i[2:0];
    end
  end

  // Level interrupt
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |((irq_stat_r | evt) & irq_mask_r);
    end
  end

  // APB answer in the access cycle, no wait states
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      pready_o <= setup;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (setup) begin
        case (ofs)
          `ISB_OFS_CTRL: prdata_o <= {16'h0000, avg_r};
          `ISB_OFS_STATUS: prdata_o <= {16'h0000, lim_cnt_r, status_o};
          `ISB_OFS_IRQ_STAT: prdata_o <= {29'h0, irq_stat_r};
          `ISB_OFS_IRQ_MASK: prdata_o <= {29'h0, irq_mask_r};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  sequence s_quiet_long;
    ce_i && avg_r < 16'h000A && nov_cnt_r >= 8'h0A;
  endsequence

  AST_GEN_SHORT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R1]
    s_quiet_long |=> status_o[0])
    else $error("general fault missing after 10 s without value");
  AST_GEN_SHORT_OK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R1]
    (ce_i && avg_r < 16'h000A && nov_cnt_r < 8'h0A) |=> !status_o[0])
    else $error("general fault raised too early");
  AST_GEN_LONG: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R2]
    (ce_i && avg_r >= 16'h000A) |=>
    (status_o[0] == ($past({buf_count_i, 1'b0}) < {1'b0, $past(avg_r)})))
    else $error("general fault disagrees with half-full test");
  AST_FILL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R3]
    ce_i ##1 ce_i |=> status_o[3:1] == $past(fif.code))
    else $error("fill bits do not carry fill code");
  AST_STATIC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R4]
    (ce_i && (lim_cnt_r > 8'h3C || nov_cnt_r > 8'h3C)) |=> status_o[5])
    else $error("static fault missing after one minute");
  AST_STATIC_OK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R4]
    (ce_i && lim_cnt_r <= 8'h3C && nov_cnt_r <= 8'h3C) |=> !status_o[5])
    else $error("static fault raised within one minute");
  AST_HCRIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R5]
    ce_i |=> status_o[6] == $past(heat_crit_i))
    else $error("heating criterion bit wrong");
  AST_HEAT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R6]
    ce_i |=> status_o[7] == $past(heat_on_i))
    else $error("heating on bit wrong");
  AST_RSVD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R7]
    status_o[4] == 1'b0)
    else $error("reserved bit set");
endmodule : isb_status_encoder

// ---- isb_status_encoder_tb.sv ----
// Self-checking bench of the status byte encoder
`timescale 1ns/100ps
module isb_status_encoder_tb;
  import isb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, smp = 1'b0, lim = 1'b0;
  logic hcrit = 1'b0, hon = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, perr;
  logic ce = 1'b1;
  logic [7:0] status;
  isb_byte_t tele;
  int n_mismatch = 0, compares = 0, cyc = 0;
  // Clock, 100 MHz
  always #5 clk = ~clk;
  isb_status_encoder #(.AW(8)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .tick_1s_i(tick), .sample_valid_i(smp), .buf_count_i(cnt),
    .sound_temperature_limit_i(lim), .heat_crit_i(hcrit), .heat_on_i(hon),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .status_o(status),
    .irq_o(irq));
  isb_host_model HOST (.ref_clk_i(clk), .rst_n_i(rst_n), .tick_1s_i(tick),
    .status_i(status), .telegram_o(tele));
  // Closing report
  task summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc_n
  task pulse(input bit s);
    @(posedge clk);
    if (s) smp <= 1'b1;
    else tick <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    tick <= 1'b0;
  endtask : pulse
  // APB transfer, holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Heating bits, reserved bit, host telegram, interrupt
  task t_heat;
    apb(1'b1, 8'h0C, 32'h0000_0004);
    hcrit <= 1'b1;
    hon <= 1'b1;
    cyc_n(3);
    chk(status & 8'hD0, 8'hC0);
    chk(irq, 1'b1);
    pulse(1'b0);
    cyc_n(1);
    chk(tele & 8'hD0, 8'hC0);
    apb(1'b1, 8'h08, 32'h0000_0004);
    hcrit <= 1'b0;
    cyc_n(3);
    chk(status & 8'hD0, 8'h80);
    chk(irq, 1'b0);
    hon <= 1'b0;
    cyc_n(3);
    chk(status & 8'hD0, 8'h00);
  endtask : t_heat
  // Fill code and general fault, averaging time 10
  task t_fill;
    logic [15:0] c[5] = '{16'h1, 16'h2, 16'h4, 16'h5, 16'hA};
    logic [3:0] e[5] = '{4'h1, 4'h3, 4'h7, 4'h6, 4'hE};
    for (int i = 0; i < 5; i++) begin
      cnt <= c[i];
      cyc_n(4);
      chk(status & 8'h1F, {4'h0, e[i]});
    end
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0000_000E);
  endtask : t_fill
  // Ten seconds without a value, averaging time 5
  task t_noval;
    apb(1'b1, 8'h00, 32'h0000_0005);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0005);
    pulse(1'b1);
    repeat (9) pulse(1'b0);
    cyc_n(2);
    chk(status[0], 1'b0);
    pulse(1'b0);
    cyc_n(2);
    chk(status[0], 1'b1);
    pulse(1'b1);
    cyc_n(3);
    chk(status[0], 1'b0);
    apb(1'b1, 8'h00, 32'h0000_000A);
  endtask : t_noval
  // Lasting limit violation, values keep coming
  task t_static;
    lim <= 1'b1;
    for (int i = 1; i <= 61; i++) begin
      pulse(1'b1);
      pulse(1'b0);
      cyc_n(2);
      chk(status[5], (i == 61));
    end
    lim <= 1'b0;
  endtask : t_static
  // Clock enable low freezes the status byte
  task t_freeze;
    ce <= 1'b0;
    hon <= 1'b1;
    cyc_n(3);
    chk(status[7], 1'b0);
    ce <= 1'b1;
    cyc_n(3);
    chk(status[7], 1'b1);
    hon <= 1'b0;
    cyc_n(2);
  endtask : t_freeze
  initial begin
    cyc_n(4);
    rst_n <= 1'b1;
    chk(status, 8'h00);
    t_heat();
    t_fill();
    t_noval();
    t_static();
    t_freeze();
    apb(1'b0, 8'h10, 32'h0);
    chk(perr, 1'b1);
    chk(q, 32'h0);
    summarize();
  end
endmodule : isb_status_encoder_tb
